// file: verilog/tcu_trace_capture_unit.sv
// trace capture unit: capture, compression, history and trace port
//
// The register addresses and the Wishbone slave port were decided locally.
`timescale 1ns/100ps
module tcu_trace_capture_unit (
  input wire logic i_clk_sys,
  input wire logic i_arst_n,
  // wishbone classic slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // cpu side events
  input wire tcu_pkg::tcu_br_t i_branch,
  input wire tcu_pkg::tcu_bus_t i_lbus,
  input wire tcu_pkg::tcu_bus_t i_sbus,
  input wire tcu_pkg::tcu_sw_t i_swtr,
  output logic o_cpu_stall,
  // trace output port
  input wire logic i_trace_port_clock,
  output logic [3:0] o_trace_data,
  output logic o_trace_valid
);
  logic [15:0] ctrl; // control bits
  logic [31:0] wa_lo, wa_hi, wb_lo, wb_hi; // window ranges
  logic [2:0] hsel; // history read index
  logic [31:0] hist_src [8]; // branch history sources
  logic [31:0] hist_dst [8]; // branch history destinations
  logic [2:0] hist_ptr; // next slot to write
  logic [3:0] hist_cnt; // entries held, saturates at depth
  logic [31:0] prev_src, prev_win; // last output addresses
  tcu_pkg::tcu_rec_t pend; // record waiting for the port
  logic pend_full;
  tcu_pkg::tcu_rec_t shf; // record being shifted out
  logic lost_flag, wait_flag; // markers owed to the port
  logic [2:0] ck_sync; // link clock synchroniser and edge stage
  logic link_rise;

  // shorthand control decode
  logic acq_ok, rt;
  assign acq_ok = !ctrl[tcu_pkg::C_UBC];
  assign rt = ctrl[tcu_pkg::C_RT];

  // nibble count for a compressed address
  function automatic logic [3:0] comp_nibs(input logic [31:0] a,
                                           input logic [31:0] p);
    if (a[31:4] == p[31:4]) comp_nibs = 4'h1;
    else if (a[31:8] == p[31:8]) comp_nibs = 4'h2;
    else if (a[31:16] == p[31:16]) comp_nibs = 4'h4;
    else comp_nibs = 4'h8;
  endfunction

  // pack kind, count, low address nibbles and optional data
  function automatic tcu_pkg::tcu_rec_t mk_rec(input logic [3:0] kind,
      input logic [3:0] an, input logic [31:0] a, input logic has_d,
      input logic [31:0] d);
    logic [31:0] msk;
    logic [79:0] body;
    msk = (32'h00000001 << (4 * an)) - 32'h00000001;
    body = {72'h0, an, kind};
    body = body | ({48'h0, a & msk} << 8);
    if (has_d) body = body | ({48'h0, d} << (8 + 4 * an));
    mk_rec.body = body;
    mk_rec.nibs = 5'h02 + {1'b0, an} + (has_d ? 5'h08 : 5'h00);
  endfunction

  // window hit on the chosen bus with read/write filter
  function automatic logic win_hit(input logic en, input logic sys,
      input logic [1:0] rw, input logic [31:0] lo, input logic [31:0] hi,
      input tcu_pkg::tcu_bus_t lb, input tcu_pkg::tcu_bus_t sb);
    logic rw_ok;
    rw_ok = 1'b0;
    if (sys)
    begin
      // system bus: cpu or dma, cache hits never appear here
      rw_ok = sb.we ? rw[1] : rw[0];
      win_hit = en && sb.valid && !sb.hit && rw_ok
        && sb.addr[27:0] >= lo[27:0] && sb.addr[27:0] <= hi[27:0];
    end
    else
    begin
      // local bus: every cpu cycle, hits included
      rw_ok = lb.we ? rw[1] : rw[0];
      win_hit = en && lb.valid && rw_ok
        && lb.addr >= lo && lb.addr <= hi;
    end
  endfunction

  // event selection, branch first, then a, b, software
  logic br_keep, hit_a, hit_b, cand_v, cand_win, cand_br;
  logic [31:0] br_src, cand_addr;
  tcu_pkg::tcu_bus_t wbus;
  tcu_pkg::tcu_rec_t cand;
  logic [3:0] cand_an;
  assign br_keep = i_branch.valid && !i_branch.zero_disp
    && !(i_branch.by_reset && i_branch.dst == tcu_pkg::RESET_VEC);
  assign br_src = i_branch.exc_done ? i_branch.src + tcu_pkg::INSN_STEP
                                    : i_branch.src;
  assign hit_a = win_hit(ctrl[tcu_pkg::C_CHA], ctrl[tcu_pkg::C_A_SYS],
    ctrl[tcu_pkg::C_A_RW+:2], wa_lo, wa_hi, i_lbus, i_sbus);
  assign hit_b = win_hit(ctrl[tcu_pkg::C_CHB], ctrl[tcu_pkg::C_B_SYS],
    ctrl[tcu_pkg::C_B_RW+:2], wb_lo, wb_hi, i_lbus, i_sbus);

  // build the candidate record
  always_comb
  begin
    cand = '0;
    cand_v = 1'b0;
    cand_win = 1'b0;
    cand_br = 1'b0;
    cand_an = 4'h0;
    cand_addr = 32'h0;
    wbus = (hit_a ? ctrl[tcu_pkg::C_A_SYS] : ctrl[tcu_pkg::C_B_SYS])
           ? i_sbus : i_lbus;
    if (ctrl[tcu_pkg::C_AUD] && acq_ok)
    begin
      if (br_keep && ctrl[tcu_pkg::C_BR])
      begin
        // source compressed, destination sent whole, no data
        cand_br = 1'b1;
        cand_addr = br_src;
        cand_an = comp_nibs(br_src, prev_src);
        cand = mk_rec(tcu_pkg::K_BRANCH, cand_an, br_src, 1'b1,
                      i_branch.dst);
        cand_v = 1'b1;
      end
      else if (hit_a || hit_b)
      begin
        // system bus loses the top nibble of the address
        cand_win = 1'b1;
        cand_addr = ((hit_a ? ctrl[tcu_pkg::C_A_SYS]
                            : ctrl[tcu_pkg::C_B_SYS]))
                    ? {4'h0, wbus.addr[27:0]} : wbus.addr;
        cand_an = comp_nibs(cand_addr, prev_win);
        cand = mk_rec(wbus.we ? tcu_pkg::K_WR : tcu_pkg::K_RD, cand_an,
                      cand_addr, 1'b1, wbus.data);
        cand_v = 1'b1;
      end
      else if (i_swtr.valid && ctrl[tcu_pkg::C_SW])
      begin
        // pc sent whole together with the register value
        cand_an = 4'h8;
        cand = mk_rec(tcu_pkg::K_SW, 4'h8, i_swtr.pc, 1'b1,
                      i_swtr.regv);
        cand_v = 1'b1;
      end
    end
  end

  // shifter idle and about to take a new record
  logic shf_idle, load_marker, load_pend, take, drop, hold;
  assign shf_idle = (shf.nibs == 5'h00);
  // loads avoid the link edge so an idle edge still clears valid
  assign load_marker = shf_idle && !link_rise && (lost_flag || wait_flag);
  assign load_pend = shf_idle && !link_rise && !(lost_flag || wait_flag)
    && pend_full;
  assign take = cand_v && (!pend_full || load_pend);
  assign drop = cand_v && !take && rt;
  assign hold = cand_v && !take && !rt;

  // pending slot and previous-address tracking
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      pend <= '0;
      pend_full <= 1'b0;
      prev_src <= 32'h0;
      prev_win <= 32'h0;
    end
    else
    begin
      if (take)
      begin
        pend <= cand;
        pend_full <= 1'b1;
        // reference advances only with what really goes out
        if (cand_br) prev_src <= cand_addr;
        if (cand_win) prev_win <= cand_addr;
      end
      else if (load_pend)
        pend_full <= 1'b0;
    end
  end

  // owed markers; a new cause in the load cycle wins
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      lost_flag <= 1'b0;
      wait_flag <= 1'b0;
    end
    else
    begin
      if (drop) lost_flag <= 1'b1;
      else if (load_marker && lost_flag) lost_flag <= 1'b0;
      if (hold && !o_cpu_stall) wait_flag <= 1'b1;
      else if (load_marker && !lost_flag) wait_flag <= 1'b0;
    end
  end

  // cpu stall while a held event cannot be taken
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n) o_cpu_stall <= 1'b0;
    else o_cpu_stall <= hold;
  end

  // link clock: two sync stages, third stage only for the edge
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n) ck_sync <= 3'h0;
    else ck_sync <= {ck_sync[1:0], i_trace_port_clock};
  end
  assign link_rise = ck_sync[1] && !ck_sync[2];

  // shifter: one nibble per link clock rising edge
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      shf <= '0;
      o_trace_data <= 4'h0;
      o_trace_valid <= 1'b0;
    end
    else if (load_marker)
    begin
      // markers carry neither address nor data
      shf.nibs <= 5'h02;
      shf.body <= {72'h0, 4'h0,
        lost_flag ? tcu_pkg::K_LOST : tcu_pkg::K_WAIT};
    end
    else if (load_pend)
      shf <= pend;
    else if (link_rise)
    begin
      o_trace_valid <= !shf_idle;
      o_trace_data <= shf_idle ? 4'h0 : shf.body[3:0];
      if (!shf_idle)
      begin
        shf.body <= shf.body >> 4;
        shf.nibs <= shf.nibs - 5'h01;
      end
    end
  end

  // internal branch history, eight most recent pairs
  logic hist_wr;
  assign hist_wr = ctrl[tcu_pkg::C_INT] && acq_ok && br_keep
    && !(ctrl[tcu_pkg::C_STOP] && hist_cnt == tcu_pkg::HIST_DEPTH);
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      hist_ptr <= 3'h0;
      hist_cnt <= 4'h0;
    end
    else if (hist_wr)
    begin
      // wraps over the oldest when continue mode is on
      hist_ptr <= hist_ptr + 3'h1;
      if (hist_cnt != tcu_pkg::HIST_DEPTH) hist_cnt <= hist_cnt + 4'h1;
    end
  end

  // history storage, no reset needed for the data
  always_ff @(posedge i_clk_sys)
  begin
    if (hist_wr)
    begin
      hist_src[hist_ptr] <= br_src;
      hist_dst[hist_ptr] <= i_branch.dst;
    end
  end

  // wishbone: ack one cycle after the strobe, dropped the next
  logic wb_req, wb_wr;
  assign wb_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
  assign wb_wr = wb_req && i_wb_we && (i_wb_sel == 4'hF);
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      ctrl <= tcu_pkg::CTRL_RST;
      wa_lo <= 32'h0;
      wa_hi <= 32'h0;
      wb_lo <= 32'h0;
      wb_hi <= 32'h0;
      hsel <= 3'h0;
    end
    else if (wb_wr)
    begin
      // partial writes are ignored, the cycle is still acked
      case (i_wb_adr)
        tcu_pkg::ADR_CTRL: ctrl <= i_wb_dat[15:0];
        tcu_pkg::ADR_WA_LO: wa_lo <= i_wb_dat;
        tcu_pkg::ADR_WA_HI: wa_hi <= i_wb_dat;
        tcu_pkg::ADR_WB_LO: wb_lo <= i_wb_dat;
        tcu_pkg::ADR_WB_HI: wb_hi <= i_wb_dat;
        tcu_pkg::ADR_HSEL: hsel <= i_wb_dat[2:0];
        default: ;
      endcase
    end
  end

  // read mux and ack
  always_ff @(posedge i_clk_sys or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0;
    end
    else
    begin
      o_wb_ack <= wb_req;
      if (wb_req && !i_wb_we)
      begin
        case (i_wb_adr)
          tcu_pkg::ADR_CTRL: o_wb_dat <= {16'h0, ctrl};
          tcu_pkg::ADR_WA_LO: o_wb_dat <= wa_lo;
          tcu_pkg::ADR_WA_HI: o_wb_dat <= wa_hi;
          tcu_pkg::ADR_WB_LO: o_wb_dat <= wb_lo;
          tcu_pkg::ADR_WB_HI: o_wb_dat <= wb_hi;
          tcu_pkg::ADR_STATUS: o_wb_dat <= {21'h0, hist_ptr, hist_cnt,
            lost_flag, wait_flag, pend_full, !shf_idle};
          tcu_pkg::ADR_HSEL: o_wb_dat <= {29'h0, hsel};
          tcu_pkg::ADR_HSRC: o_wb_dat <= hist_src[hsel];
          tcu_pkg::ADR_HDST: o_wb_dat <= hist_dst[hsel];
          default: o_wb_dat <= 32'h0; // unmapped reads zero
        endcase
      end
    end
  end

  // checks on the block's own behaviour
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_arst_n);
  sequence s_drop;
    drop;
  endsequence
  sequence s_lost_out;
    lost_flag ##[0:300] (load_marker && lost_flag);
  endsequence
  stall_mode_a: assert property (o_cpu_stall |-> !rt)
    else $error("stall raised in realtime mode");
  lost_marker_a: assert property (s_drop |=> s_lost_out)
    else $error("dropped record without lost marker");
  wait_marker_a: assert property ($rose(o_cpu_stall) |-> wait_flag)
    else $error("stall without cpu-wait marker");
  hist_stop_a: assert property (ctrl[tcu_pkg::C_STOP] &&
    hist_cnt == tcu_pkg::HIST_DEPTH |=> $stable(hist_ptr))
    else $error("history advanced while stopped");
  zero_disp_a: assert property (i_branch.valid && i_branch.zero_disp
    |=> $stable(hist_ptr) && !$rose(pend_full))
    else $error("zero displacement branch recorded");
  ubc_user_a: assert property (ctrl[tcu_pkg::C_UBC]
    |-> !take && !hist_wr)
    else $error("acquisition while break unit is user owned");
  full_addr_a: assert property (cand_v && (cand_br || cand_win) &&
    cand_addr[31:16] != (cand_br ? prev_src[31:16] : prev_win[31:16])
    |-> cand.nibs == 5'h12)
    else $error("full address not sent after upper half change");
  sys_top_a: assert property (cand_win && (hit_a ? ctrl[tcu_pkg::C_A_SYS]
    : ctrl[tcu_pkg::C_B_SYS]) |-> cand_addr[31:28] == 4'h0)
    else $error("system bus record kept top address nibble");
  shift_step_a: assert property (link_rise && !shf_idle && !load_marker
    && !load_pend |=> o_trace_valid && shf.nibs == $past(shf.nibs) - 5'h01)
    else $error("trace nibble not shifted on link edge");
endmodule

// file: verilog/tcu_pkg.sv
// constants, types and record layout for the trace capture unit
// Notes on behaviour
// - two window channels, separately enabled, own ranges
// - local bus captures cpu cycles, cache hits too
// - system bus captures cpu or dma, no hits
// - system bus records hold 28 address bits
// - software trace sends pc and register value
// - addresses sent as difference from previous
// - send 16, 8 or 4 low bits on match
// - realtime drop emits a lost marker
// - non-realtime stall emits a cpu-wait marker
// - busy output stalls cpu or drops record
// - full history overwrites or stops acquiring
// - channel captures reads, writes or both
// - record contents depend on trace kind
// - history keeps last eight branch pairs
// - skip zero-displacement and reset-vector branches
// - completion exception records following address
// - no acquisition while break unit is user's
package tcu_pkg;
  // register byte addresses
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_WA_LO = 8'h04;
  localparam logic [7:0] ADR_WA_HI = 8'h08;
  localparam logic [7:0] ADR_WB_LO = 8'h0C;
  localparam logic [7:0] ADR_WB_HI = 8'h10;
  localparam logic [7:0] ADR_STATUS = 8'h14;
  localparam logic [7:0] ADR_HSEL = 8'h18;
  localparam logic [7:0] ADR_HSRC = 8'h1C;
  localparam logic [7:0] ADR_HDST = 8'h20;
  // control field positions
  localparam int C_AUD = 0;
  localparam int C_INT = 1;
  localparam int C_BR = 2;
  localparam int C_CHA = 3;
  localparam int C_CHB = 4;
  localparam int C_SW = 5;
  localparam int C_RT = 6;
  localparam int C_STOP = 7;
  localparam int C_UBC = 8;
  localparam int C_A_SYS = 9;
  localparam int C_A_RW = 10;
  localparam int C_B_SYS = 12;
  localparam int C_B_RW = 13;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  // read / write selection codes
  localparam logic [1:0] RW_RD = 2'h1;
  localparam logic [1:0] RW_WR = 2'h2;
  // record kind nibbles
  localparam logic [3:0] K_BRANCH = 4'h1;
  localparam logic [3:0] K_RD = 4'h2;
  localparam logic [3:0] K_WR = 4'h3;
  localparam logic [3:0] K_SW = 4'h4;
  localparam logic [3:0] K_LOST = 4'h5;
  localparam logic [3:0] K_WAIT = 4'h6;
  localparam logic [31:0] RESET_VEC = 32'hA0000000;
  localparam logic [31:0] INSN_STEP = 32'h00000002;
  localparam logic [3:0] HIST_DEPTH = 4'h8;
  // one branch event from the cpu
  typedef struct packed {
    logic valid; logic zero_disp; logic by_reset; logic exc_done;
    logic [31:0] src; logic [31:0] dst;
  } tcu_br_t;
  // one bus cycle seen on a bus
  typedef struct packed {
    logic valid; logic we; logic hit; logic [31:0] addr; logic [31:0] data;
  } tcu_bus_t;
  // one software trace event
  typedef struct packed {
    logic valid; logic [31:0] pc; logic [31:0] regv;
  } tcu_sw_t;
  // serialised record: nibble count and payload, low nibble first
  typedef struct packed {
    logic [4:0] nibs; logic [79:0] body;
  } tcu_rec_t;
endpackage

// file: verification/tcu_probe.sv
// trace probe model: makes the trace port clock and gathers nibbles
`timescale 1ns/100ps
module tcu_probe (
  input wire logic i_run,
  input wire logic [3:0] i_trace_data,
  input wire logic i_trace_valid,
  output logic o_trace_port_clock
);
  logic [3:0] q[$]; // nibbles in arrival order
  initial o_trace_port_clock = 1'b0;
  // 800 ns period, far below the card limit
  always #400
  begin
    // clock stands still while no capture is wanted
    if (i_run)
      o_trace_port_clock = ~o_trace_port_clock;
    else
      o_trace_port_clock = 1'b0;
  end
  // sample mid-nibble, away from the launching edge
  always @(negedge o_trace_port_clock)
  begin
    if (i_trace_valid === 1'b1)
      q.push_back(i_trace_data);
  end
endmodule

// file: verification/tb.sv
// self-checking bench for the trace capture unit
`timescale 1ns/100ps
module tb;
  logic clk = 1'b0; // system clock
  logic arst_n = 1'b0; // async reset, active low
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, run = 1'b0, stall, tclk, tval;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat;
  logic [3:0] tdat;
  tcu_pkg::tcu_br_t br = '0; // branch events
  tcu_pkg::tcu_bus_t lb = '0, sb = '0; // local and system bus
  tcu_pkg::tcu_sw_t sw = '0; // software trace
  int n_mismatch = 0, n_tests = 0, cyc_cnt = 0;
  logic stall_seen = 1'b0; // any stall since last clear
  logic [31:0] bp = 32'h0, wp = 32'h0; // reference addresses
  always #50 clk = ~clk;
  tcu_trace_capture_unit i_dut (.i_clk_sys(clk), .i_arst_n(arst_n),
    .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
    .i_wb_sel(4'hF), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_branch(br), .i_lbus(lb), .i_sbus(sb), .i_swtr(sw),
    .o_cpu_stall(stall), .i_trace_port_clock(tclk),
    .o_trace_data(tdat), .o_trace_valid(tval));
  tcu_probe i_pr (.i_run(run), .i_trace_data(tdat), .i_trace_valid(tval),
    .o_trace_port_clock(tclk));
  // hang guard and stall watcher
  always @(posedge clk)
  begin
    cyc_cnt++;
    if (stall === 1'b1)
      stall_seen = 1'b1;
    if (cyc_cnt == 30000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task report_and_stop;
    if (n_mismatch == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one classic cycle, held until ack is sampled
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    wb(1'b1, a, d, x);
  endtask
  task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    wb(1'b0, a, 32'h0, x);
    chk(nm, x, e);
  endtask
  function logic [31:0] cb(input int b);
    return 32'h1 << b;
  endfunction
  // nibble count the compression should pick
  function logic [3:0] exp_n(input logic [31:0] p, input logic [31:0] c);
    if (p[31:4] == c[31:4]) return 4'h1;
    if (p[31:8] == c[31:8]) return 4'h2;
    if (p[31:16] == c[31:16]) return 4'h4;
    return 4'h8;
  endfunction
  task nib(output logic [3:0] v);
    while (i_pr.q.size() == 0) @(posedge clk);
    v = i_pr.q.pop_front();
  endtask
  // one record off the wire: kind, count, address, data
  task get_rec(output logic [3:0] k, output logic [3:0] n,
    output logic [31:0] a, output logic [31:0] d);
    logic [3:0] x;
    a = 32'h0;
    d = 32'h0;
    nib(k);
    nib(n);
    for (int i = 0; i < n; i++)
    begin
      nib(x);
      a[4*i+:4] = x;
    end
    if (k !== tcu_pkg::K_LOST && k !== tcu_pkg::K_WAIT)
      for (int i = 0; i < 8; i++)
      begin
        nib(x);
        d[4*i+:4] = x;
      end
  endtask
  task chk_rec(input logic [3:0] ek, input logic [31:0] ea,
    input logic [31:0] ed, inout logic [31:0] p);
    logic [3:0] k, n, en;
    logic [31:0] a, d;
    get_rec(k, n, a, d);
    en = exp_n(p, ea);
    chk("kind", {28'h0, k}, {28'h0, ek});
    chk("count", {28'h0, n}, {28'h0, en});
    chk("addr", a, (en == 4'h8) ? ea : ea & ((32'h1 << (4*en)) - 1));
    chk("data", d, ed);
    p = ea;
  endtask
  // branch held while the cpu is told to stall
  task fire(input logic z, input logic r, input logic e,
    input logic [31:0] s, input logic [31:0] dt);
    @(posedge clk);
    br <= '{1'b1, z, r, e, s, dt};
    do
    begin
      @(posedge clk);
      #1;
    end
    while (stall === 1'b1);
    br <= '0;
  endtask
  task bus(input logic s, input logic w, input logic h,
    input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    if (s)
      sb <= '{1'b1, w, h, a, d};
    else
      lb <= '{1'b1, w, h, a, d};
    @(posedge clk);
    lb <= '0;
    sb <= '0;
  endtask
  task quiet(input string nm);
    repeat (300) @(posedge clk);
    chk(nm, i_pr.q.size(), 32'h0);
  endtask
  // drain everything and tally kinds
  task collect(output int nb, output logic lost, output logic wt,
    output logic [31:0] ld);
    logic [3:0] k, n;
    logic [31:0] a, d;
    {nb, lost, wt} = '0;
    repeat (800) @(posedge clk);
    while (i_pr.q.size() > 0)
    begin
      get_rec(k, n, a, d);
      if (k === tcu_pkg::K_BRANCH)
      begin
        nb++;
        ld = d;
      end
      lost |= (k === tcu_pkg::K_LOST);
      wt |= (k === tcu_pkg::K_WAIT);
    end
  endtask
  task t_regs;
    rdc("ctrl reset", tcu_pkg::ADR_CTRL, {16'h0, tcu_pkg::CTRL_RST});
    rdc("unmapped", 8'hFC, 32'h0);
  endtask
  task automatic t_branch;
    logic [31:0] s[5] = '{32'h12345678, 32'h123456A6, 32'h123456A9,
      32'h12340000, 32'h12340010};
    wr(tcu_pkg::ADR_CTRL, cb(tcu_pkg::C_AUD) | cb(tcu_pkg::C_BR));
    for (int i = 0; i < 5; i++)
    begin
      fire(1'b0, 1'b0, 1'b0, s[i], 32'h1000 + i);
      chk_rec(tcu_pkg::K_BRANCH, s[i], 32'h1000 + i, bp);
    end
    fire(1'b1, 1'b0, 1'b0, 32'h12340030, 32'h12340030);
    fire(1'b0, 1'b1, 1'b0, 32'h12340040, tcu_pkg::RESET_VEC);
    quiet("filtered");
    fire(1'b0, 1'b0, 1'b1, 32'h12340020, 32'h800);
    chk_rec(tcu_pkg::K_BRANCH, 32'h12340022, 32'h800, bp);
    wr(tcu_pkg::ADR_CTRL, cb(tcu_pkg::C_AUD) | cb(tcu_pkg::C_BR)
      | cb(tcu_pkg::C_UBC));
    fire(1'b0, 1'b0, 1'b0, 32'h55555550, 32'h900);
    quiet("user owned");
  endtask
  task t_window;
    wr(tcu_pkg::ADR_WA_LO, 32'h1000);
    wr(tcu_pkg::ADR_WA_HI, 32'h1FFF);
    wr(tcu_pkg::ADR_WB_LO, 32'h01008000);
    wr(tcu_pkg::ADR_WB_HI, 32'h01008FFF);
    wr(tcu_pkg::ADR_CTRL, cb(tcu_pkg::C_AUD) | cb(tcu_pkg::C_CHA)
      | cb(tcu_pkg::C_CHB) | (tcu_pkg::RW_RD << tcu_pkg::C_A_RW)
      | cb(tcu_pkg::C_B_SYS) | (32'h3 << tcu_pkg::C_B_RW));
    bus(1'b0, 1'b0, 1'b1, 32'h1004, 32'h2746);
    chk_rec(tcu_pkg::K_RD, 32'h1004, 32'h2746, wp);
    bus(1'b0, 1'b1, 1'b0, 32'h1008, 32'h1);
    bus(1'b1, 1'b0, 1'b1, 32'hF1008010, 32'h2);
    bus(1'b0, 1'b0, 1'b0, 32'h2000, 32'h3);
    quiet("win skip");
    bus(1'b1, 1'b1, 1'b0, 32'hF1008020, 32'h1AE5);
    chk_rec(tcu_pkg::K_WR, 32'h01008020, 32'h1AE5, wp);
  endtask
  task t_sw;
    logic [31:0] p;
    p = 32'h0;
    wr(tcu_pkg::ADR_CTRL, cb(tcu_pkg::C_AUD) | cb(tcu_pkg::C_SW));
    @(posedge clk);
    sw <= '{1'b1, 32'h76542222, 32'h0000000A};
    @(posedge clk);
    sw <= '0;
    chk_rec(tcu_pkg::K_SW, 32'h76542222, 32'h0000000A, p);
  endtask
  task t_mode(input logic rt);
    int nb;
    logic lost, wt;
    logic [31:0] ld;
    wr(tcu_pkg::ADR_CTRL, cb(tcu_pkg::C_AUD) | cb(tcu_pkg::C_BR)
      | (rt ? cb(tcu_pkg::C_RT) : 32'h0));
    stall_seen = 1'b0;
    for (int i = 0; i < 3; i++)
      fire(1'b0, 1'b0, 1'b0, 32'h00770000 + 32'h100 * i, 32'hD0 + i);
    collect(nb, lost, wt, ld);
    chk("stalled", {31'h0, stall_seen}, {31'h0, ~rt});
    chk("lost", {31'h0, lost}, {31'h0, rt});
    chk("wait", {31'h0, wt}, {31'h0, ~rt});
    chk("dropped", {31'h0, nb < 3}, {31'h0, rt});
    if (!rt)
      chk("last dst", ld, 32'hD2);
  endtask
  task t_hist;
    logic [31:0] x;
    wr(tcu_pkg::ADR_CTRL, cb(tcu_pkg::C_INT) | cb(tcu_pkg::C_BR)
      | cb(tcu_pkg::C_RT));
    for (int i = 0; i < 9; i++)
      fire(1'b0, 1'b0, 1'b0, 32'h5000 + 32'h10 * i, 32'h6000 + i);
    wb(1'b0, tcu_pkg::ADR_STATUS, 32'h0, x);
    chk("hist count", {28'h0, x[7:4]}, 32'h8);
    wr(tcu_pkg::ADR_HSEL, {29'h0, x[10:8] - 3'h1});
    rdc("newest src", tcu_pkg::ADR_HSRC, 32'h5080);
    rdc("newest dst", tcu_pkg::ADR_HDST, 32'h6008);
    wr(tcu_pkg::ADR_CTRL, cb(tcu_pkg::C_INT) | cb(tcu_pkg::C_BR)
      | cb(tcu_pkg::C_RT) | cb(tcu_pkg::C_STOP));
    fire(1'b0, 1'b0, 1'b0, 32'h7000, 32'h7100);
    wb(1'b0, tcu_pkg::ADR_STATUS, 32'h0, x);
    chk("hist stopped", {29'h0, x[10:8]}, 32'h1);
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    run <= 1'b1;
    t_regs();
    t_branch();
    t_window();
    t_sw();
    t_mode(1'b0);
    t_mode(1'b1);
    t_hist();
    report_and_stop();
  end
endmodule
